// File: logic/sbc_pkg.sv
// Package: offsets, layouts, reset values and timing of the bus status bank
package sbc_pkg;

  // ********************************************************
  // Register addresses (7-bit command address)
  // ********************************************************
  localparam logic [6:0] ADDR_DEV = 7'h43;
  localparam logic [6:0] ADDR_BUS_A = 7'h44;
  localparam logic [6:0] ADDR_BUS_B = 7'h45;

  // ********************************************************
  // Values after power-on or soft reset
  // ********************************************************
  localparam logic [7:0] RST_DEV = 8'h00;
  localparam logic [7:0] RST_BUS_A = 8'h00;
  localparam logic [7:0] RST_BUS_B = 8'h00;

  // ********************************************************
  // Bit masks: implemented, clearable, kept on restart
  // ********************************************************
  localparam logic [7:0] IMPL_BUS_A = 8'h67;
  localparam logic [7:0] IMPL_BUS_B = 8'h1e;
  localparam logic [7:0] CLR_DEV = 8'hf3;
  localparam logic [7:0] KEEP_DEV = 8'hff;
  localparam logic [7:0] KEEP_BUS_A = 8'h67;
  localparam logic [7:0] KEEP_BUS_B = 8'h1e;

  // ********************************************************
  // Field positions (low bit of each field)
  // ********************************************************
  localparam int POS_CAUSE = 6;
  localparam int POS_PIN_HIGH = 5;
  localparam int POS_FSI_FAULT = 4;
  localparam int POS_WD_CNT = 2;
  localparam int POS_BAD_CMD = 1;
  localparam int POS_FO_ACT = 0;
  localparam int POS_LIN1 = 5;
  localparam int POS_CAN = 1;
  localparam int POS_CAN_LOW = 0;
  localparam int POS_LIN3 = 3;
  localparam int POS_LIN2 = 1;

  // ********************************************************
  // Codes
  // ********************************************************
  localparam logic [1:0] CAUSE_FAIL = 2'h1;
  localparam logic [1:0] CAUSE_SLEEP = 2'h2;
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_THERM = 2'h1;
  localparam logic [1:0] CODE_TXD = 2'h2;
  localparam logic [1:0] CODE_BUS = 2'h3;
  localparam logic [1:0] WD_MAX = 2'h2;

  // CAN operating mode as seen by the comparator enable
  typedef enum logic [1:0] {CAN_OFF, CAN_WAKE, CAN_RXONLY, CAN_NORMAL} sbc_can_mode_t;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int TX_EN_TIME_NS = 1000;
  localparam int TX_EN_CYCLES = (TX_EN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: logic/sbc_tx_recovery.sv
// Transmitter lock-out and recovery for one bus transceiver
`timescale 1ns/1ns
`default_nettype none

module sbc_tx_recovery
  import sbc_pkg::*;
#(
  parameter int EN_CYCLES = TX_EN_CYCLES
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Fault causes
  input wire logic tx_stuck_i,
  input wire logic bus_stuck_i,
  input wire logic thermal_i,
  input wire logic supply_low_i,
  // Recovery conditions
  input wire logic wake_or_off_i,
  input wire logic txd_i,
  input wire logic bus_recessive_i,
  // Transmitter enable
  output logic tx_en_o
);

  localparam int CW = $clog2(EN_CYCLES + 1);

  generate
    if (EN_CYCLES < 1)
    begin : g_bad
      $error("EN_CYCLES must be at least one");
    end
  endgenerate

  typedef enum logic [1:0] {TX_RUN, TX_BLOCK, TX_ARM} sbc_tx_state_t;

  sbc_tx_state_t state;
  sbc_tx_state_t next_state;
  logic tx_blk;
  logic bus_blk;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  // Each cause has its own way out; thermal and supply wait for the level
  wire fault_any = tx_stuck_i | bus_stuck_i | thermal_i | supply_low_i;
  wire tx_ok = !tx_blk || txd_i || wake_or_off_i;
  wire bus_ok = !bus_blk || bus_recessive_i || wake_or_off_i;
  wire released = tx_ok && bus_ok && !thermal_i && !supply_low_i;
  wire hold_done = txd_i && (cnt == CW'(EN_CYCLES - 1));

  // Next state: a low on the transmit input restarts the hold time
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      TX_RUN:
      begin
        if (fault_any)
          next_state = TX_BLOCK;
      end
      TX_BLOCK:
      begin
        next_cnt = '0;
        if (released && !fault_any)
          next_state = TX_ARM;
      end
      TX_ARM:
      begin
        if (fault_any)
          next_state = TX_BLOCK;
        else if (!txd_i)
          next_cnt = '0;
        else if (hold_done)
          next_state = TX_RUN;
        else
          next_cnt = cnt + CW'(1);
      end
    endcase
  end

  // State and cause flags
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= TX_RUN;
      cnt <= '0;
      tx_blk <= 1'b0;
      bus_blk <= 1'b0;
      tx_en_o <= 1'b1;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      tx_blk <= tx_stuck_i | (tx_blk & (next_state == TX_BLOCK));
      bus_blk <= bus_stuck_i | (bus_blk & (next_state == TX_BLOCK));
      tx_en_o <= (next_state == TX_RUN);
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  chk_hold_before_en: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(tx_en_o) |-> $past(txd_i) && $past(state) == TX_ARM)
    else $error("transmitter enabled without transmit input hold");
  chk_fault_blocks: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    fault_any |=> !tx_en_o)
    else $error("transmitter stays on during a fault");
  cov_recover: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(tx_en_o));

endmodule // sbc_tx_recovery

`default_nettype wire

// File: logic/sbc_bus_status.sv
// Device, CAN and LIN status registers read and cleared by command frames
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Bits 7:6 hold restart cause: 01 failure or fail-safe wake, 10 sleep wake.
// - Restart cause reads 00 only after the controller clears it or after a power-on or soft reset.
// - Device register keeps all bits on restart; power-on and soft reset zero it.
// - Bit 5 sets on reset pin clamped high, held until cleared.
// - Bit 4 sets on a wrong fail-safe input pattern, held until cleared.
// - Bits 3:2 count watchdog failures, saturating at two.
// - Watchdog counter clears on a good trigger; no other bit self-clears.
// - An invalid command is not executed and sets bit 1.
// - The bad-command flag clears only by a clear command or by a power-on or soft reset.
// - Bit 0 sets while the fail outputs are active, held until cleared.
// - Each LIN channel has a 2-bit fault code at its own field.
// - CAN fault code: 01 thermal, 10 transmit stuck, 11 bus stuck.
// - CAN supply low sets bit 0 and disables the CAN transmitter.
// - The CAN supply comparator runs in normal, receive-only, or woken mode.
// - Transmit-stuck lock-out ends on transmit input high or wake/off mode.
// - Bus-stuck lock-out ends on a recessive bus or wake/off mode.
// - Transmission resumes only after transmit input stays high the enable time.
// - On restart the bus registers clear the bits not marked as kept.
// - Reserved bits read zero and ignore clears.
module sbc_bus_status
  import sbc_pkg::*;
#(
  parameter int LIN_CH = 3,
  parameter int EN_CYCLES = TX_EN_CYCLES
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic soft_reset_i,
  input wire logic restart_i,
  // Decoded command frame
  input wire logic frame_valid_i,
  input wire logic [6:0] frame_addr_i,
  input wire logic frame_clear_i,
  input wire logic frame_bad_i,
  // Device events
  input wire logic restart_fail_i,
  input wire logic sleep_wake_i,
  input wire logic reset_pin_stuck_high_i,
  input wire logic failsafe_input_fault_i,
  input wire logic wdog_fail_i,
  input wire logic wdog_ok_i,
  input wire logic fail_outputs_i,
  // CAN transceiver
  input wire sbc_can_mode_t can_mode_i,
  input wire logic wake_pattern_i,
  input wire logic can_supply_low_i,
  input wire logic can_thermal_i,
  input wire logic can_tx_input_stuck_i,
  input wire logic can_bus_stuck_i,
  input wire logic can_txd_i,
  input wire logic can_bus_recessive_i,
  // LIN transceivers, bit n is channel n+1
  input wire logic [LIN_CH-1:0] lin_thermal_i,
  input wire logic [LIN_CH-1:0] lin_tx_input_stuck_i,
  input wire logic [LIN_CH-1:0] lin_bus_stuck_i,
  input wire logic [LIN_CH-1:0] lin_wake_or_off_i,
  input wire logic [LIN_CH-1:0] lin_txd_i,
  input wire logic [LIN_CH-1:0] lin_bus_recessive_i,
  // Read answer
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  // Register contents and side outputs
  output logic [7:0] device_info_status_o,
  output logic [7:0] bus_comm_status_a_o,
  output logic [7:0] bus_comm_status_b_o,
  output logic thermal_level_one_o,
  output logic can_tx_en_o,
  output logic [LIN_CH-1:0] lin_tx_en_o
);

  // Field positions are fixed for exactly three LIN channels
  generate
    if (LIN_CH != 3)
    begin : g_bad_ch
      $error("LIN_CH must be 3");
    end
  endgenerate

  // ********************************************************
  // Helpers
  // ********************************************************

  // Worst fault wins; a clear only drops the old code
  function automatic logic [1:0] fault_code(input logic th, input logic tx,
                                             input logic bus, input logic [1:0] cur,
                                             input logic clr);
    if (bus)
      return CODE_BUS;
    else if (tx)
      return CODE_TXD;
    else if (th)
      return CODE_THERM;
    else
      return clr ? CODE_NONE : cur;
  endfunction

  // Sticky flag: set beats clear
  function automatic logic sticky(input logic set, input logic cur, input logic clr);
    return set | (cur & ~clr);
  endfunction

  // ********************************************************
  // Registers
  // ********************************************************
  logic [7:0] dev;
  logic [7:0] bus_a;
  logic [7:0] bus_b;
  logic [7:0] next_dev;
  logic [7:0] next_bus_a;
  logic [7:0] next_bus_b;

  // ********************************************************
  // Command decode
  // ********************************************************
  // A bad frame touches nothing but its own flag
  wire good = frame_valid_i && !frame_bad_i;
  wire hit_dev = good && (frame_addr_i == ADDR_DEV);
  wire hit_a = good && (frame_addr_i == ADDR_BUS_A);
  wire hit_b = good && (frame_addr_i == ADDR_BUS_B);
  wire hit_any = hit_dev || hit_a || hit_b;
  wire clr_dev = hit_dev && frame_clear_i;
  wire clr_a = hit_a && frame_clear_i;
  wire clr_b = hit_b && frame_clear_i;
  wire bad_cmd = frame_valid_i && frame_bad_i;

  // Read mux; a clear frame still returns the value before clearing
  wire [7:0] rd_mux = hit_dev ? dev : hit_a ? bus_a : hit_b ? bus_b : 8'h00;

  // ********************************************************
  // Device information register
  // ********************************************************
  wire [1:0] cause = dev[POS_CAUSE+1:POS_CAUSE];
  wire [1:0] wd_cnt = dev[POS_WD_CNT+1:POS_WD_CNT];

  // Failure restart outranks a sleep wake; never falls back to 00 alone
  wire [1:0] next_cause = restart_fail_i ? CAUSE_FAIL :
                          sleep_wake_i ? CAUSE_SLEEP :
                          clr_dev ? 2'h0 : cause;

  // Counter saturates at two; a fail in the trigger cycle still counts
  wire [1:0] next_wd = wdog_fail_i ? ((wd_cnt == WD_MAX) ? WD_MAX : wd_cnt + 2'h1) :
                       wdog_ok_i ? 2'h0 : wd_cnt;

  assign next_dev[POS_CAUSE+1:POS_CAUSE] = next_cause;
  assign next_dev[POS_PIN_HIGH] = sticky(reset_pin_stuck_high_i, dev[POS_PIN_HIGH], clr_dev);
  assign next_dev[POS_FSI_FAULT] = sticky(failsafe_input_fault_i, dev[POS_FSI_FAULT], clr_dev);
  assign next_dev[POS_WD_CNT+1:POS_WD_CNT] = next_wd;
  assign next_dev[POS_BAD_CMD] = sticky(bad_cmd, dev[POS_BAD_CMD], clr_dev);
  assign next_dev[POS_FO_ACT] = sticky(fail_outputs_i, dev[POS_FO_ACT], clr_dev);

  // ********************************************************
  // CAN supply comparator
  // ********************************************************
  // Comparator off in sleep-like modes so a dead supply raises nothing
  wire cmp_en = (can_mode_i == CAN_NORMAL) || (can_mode_i == CAN_RXONLY) ||
                ((can_mode_i == CAN_WAKE) && wake_pattern_i);
  wire can_low = can_supply_low_i && cmp_en;

  // ********************************************************
  // Bus status registers
  // ********************************************************
  logic [7:0] raw_a;
  logic [7:0] raw_b;

  // Unimplemented positions stay zero and are masked again below
  always_comb
  begin
    raw_a = 8'h00;
    raw_b = 8'h00;
    raw_a[POS_LIN1+:2] = fault_code(lin_thermal_i[0], lin_tx_input_stuck_i[0],
                                    lin_bus_stuck_i[0], bus_a[POS_LIN1+:2], clr_a);
    raw_a[POS_CAN+:2] = fault_code(can_thermal_i, can_tx_input_stuck_i,
                                   can_bus_stuck_i, bus_a[POS_CAN+:2], clr_a);
    raw_a[POS_CAN_LOW] = sticky(can_low, bus_a[POS_CAN_LOW], clr_a);
    raw_b[POS_LIN2+:2] = fault_code(lin_thermal_i[1], lin_tx_input_stuck_i[1],
                                    lin_bus_stuck_i[1], bus_b[POS_LIN2+:2], clr_b);
    raw_b[POS_LIN3+:2] = fault_code(lin_thermal_i[2], lin_tx_input_stuck_i[2],
                                    lin_bus_stuck_i[2], bus_b[POS_LIN3+:2], clr_b);
  end

  assign next_bus_a = raw_a & IMPL_BUS_A;
  assign next_bus_b = raw_b & IMPL_BUS_B;

  // ********************************************************
  // Register update
  // ********************************************************
  // Soft reset loads reset values; restart drops bits outside the keep
  // masks, while events and clears of that cycle still count, so no OR
  // with the old contents can undo a clear or merge two fault codes
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dev <= RST_DEV;
      bus_a <= RST_BUS_A;
      bus_b <= RST_BUS_B;
    end
    else if (soft_reset_i)
    begin
      dev <= RST_DEV;
      bus_a <= RST_BUS_A;
      bus_b <= RST_BUS_B;
    end
    else if (restart_i)
    begin
      dev <= next_dev & KEEP_DEV;
      bus_a <= next_bus_a & KEEP_BUS_A;
      bus_b <= next_bus_b & KEEP_BUS_B;
    end
    else
    begin
      dev <= next_dev;
      bus_a <= next_bus_a;
      bus_b <= next_bus_b;
    end
  end

  // ********************************************************
  // Read answer and side outputs
  // ********************************************************
  // Answer comes one cycle after the frame; other addresses stay silent
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      thermal_level_one_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= hit_any;
      rd_data_o <= rd_mux;
      thermal_level_one_o <= can_thermal_i | (|lin_thermal_i);
    end
  end

  assign device_info_status_o = dev;
  assign bus_comm_status_a_o = bus_a;
  assign bus_comm_status_b_o = bus_b;

  // ********************************************************
  // Transmitter recovery
  // ********************************************************
  // Supply low is a CAN-only lock-out cause
  sbc_tx_recovery #(.EN_CYCLES(EN_CYCLES)) u_can_rec
  (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .tx_stuck_i(can_tx_input_stuck_i),
    .bus_stuck_i(can_bus_stuck_i),
    .thermal_i(can_thermal_i),
    .supply_low_i(can_low),
    .wake_or_off_i((can_mode_i == CAN_OFF) || (can_mode_i == CAN_WAKE)),
    .txd_i(can_txd_i),
    .bus_recessive_i(can_bus_recessive_i),
    .tx_en_o(can_tx_en_o)
  );

  // One recovery unit per LIN channel
  genvar gi;
  generate
    for (gi = 0; gi < LIN_CH; gi++)
    begin : g_lin
      sbc_tx_recovery #(.EN_CYCLES(EN_CYCLES)) u_lin_rec
      (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .tx_stuck_i(lin_tx_input_stuck_i[gi]),
        .bus_stuck_i(lin_bus_stuck_i[gi]),
        .thermal_i(lin_thermal_i[gi]),
        .supply_low_i(1'b0),
        .wake_or_off_i(lin_wake_or_off_i[gi]),
        .txd_i(lin_txd_i[gi]),
        .bus_recessive_i(lin_bus_recessive_i[gi]),
        .tx_en_o(lin_tx_en_o[gi])
      );
    end
  endgenerate

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  wire quiet = !soft_reset_i;

  chk_cause_fail: assert property (restart_fail_i && quiet |=> cause == CAUSE_FAIL)
    else $error("failure restart cause not recorded");
  chk_cause_sleep: assert property (sleep_wake_i && !restart_fail_i && quiet
    |=> cause == CAUSE_SLEEP)
    else $error("sleep wake cause not recorded");
  chk_cause_kept: assert property (cause != 2'h0 && !clr_dev && quiet |=> cause != 2'h0)
    else $error("restart cause dropped to zero without a clear");
  chk_soft_zero: assert property (soft_reset_i |=> dev == RST_DEV && bus_a == 8'h00
    && bus_b == 8'h00)
    else $error("soft reset did not zero the registers");
  chk_restart_keep: assert property (restart_i && quiet |=>
    (dev & ~CLR_DEV & 8'hcc) == ($past(dev) & ~CLR_DEV & 8'hcc) || $past(wdog_ok_i || wdog_fail_i))
    else $error("restart changed the device register");
  chk_pin_flag: assert property (reset_pin_stuck_high_i && quiet |=> dev[POS_PIN_HIGH])
    else $error("clamped reset pin not flagged");
  chk_fsi_flag: assert property (failsafe_input_fault_i && quiet |=> dev[POS_FSI_FAULT])
    else $error("fail-safe input fault not flagged");
  chk_wd_sat: assert property (wd_cnt == WD_MAX && wdog_fail_i && quiet |=> wd_cnt == WD_MAX)
    else $error("watchdog counter left saturation");
  chk_wd_clear: assert property (wdog_ok_i && !wdog_fail_i && quiet |=> wd_cnt == 2'h0)
    else $error("watchdog counter not cleared by good trigger");
  chk_bad_cmd: assert property (bad_cmd && quiet |=> dev[POS_BAD_CMD] && !rd_valid_o)
    else $error("invalid command executed or not flagged");
  chk_bad_hold: assert property (dev[POS_BAD_CMD] && !clr_dev && quiet |=> dev[POS_BAD_CMD])
    else $error("bad-command flag cleared without command");
  chk_can_low: assert property (can_low && quiet |=> bus_a[POS_CAN_LOW] ##1 !can_tx_en_o)
    else $error("CAN supply low not flagged or transmitter not off");
  chk_cmp_off: assert property (!cmp_en && !bus_a[POS_CAN_LOW] && !restart_i
    |=> !bus_a[POS_CAN_LOW])
    else $error("supply flag set with comparator disabled");
  chk_restart_bus: assert property (restart_i && quiet |=>
    (bus_a & ~IMPL_BUS_A) == 8'h00 && ((bus_b & KEEP_BUS_B) | ~($past(bus_b) & KEEP_BUS_B)) == 8'hff)
    else $error("restart changed kept bus bits");
  chk_reserved: assert property ((bus_a & ~IMPL_BUS_A) == 8'h00 && (bus_b & ~IMPL_BUS_B) == 8'h00)
    else $error("reserved bit reads one");
  chk_set_wins: assert property (clr_a && can_bus_stuck_i && quiet |=> bus_a[POS_CAN+:2] == CODE_BUS)
    else $error("event lost under a clear");
  chk_read_data: assert property (hit_any && !frame_clear_i |=> rd_valid_o
    && rd_data_o == $past(rd_mux))
    else $error("read answer wrong");

  cov_clear_dev: cover property (clr_dev ##1 cause == 2'h0);
  cov_wd_two: cover property (wd_cnt == WD_MAX);
  cov_restart: cover property (restart_i && bus_b != 8'h00);
  cov_can_rec: cover property ($rose(can_tx_en_o));

endmodule // sbc_bus_status

`default_nettype wire

// File: tb/sbc_mcu_model.sv
// Controller model that sends decoded command frames to the status bank
`timescale 1ns/1ns
`default_nettype none

module sbc_mcu_model
(
  // Clock
  input wire logic mclk_i,
  // Decoded frame towards the bank
  output logic frame_valid_o,
  output logic [6:0] frame_addr_o,
  output logic frame_clear_o,
  output logic frame_bad_o
);
  initial
  begin
    frame_valid_o = 1'b0;
    frame_addr_o = 7'h00;
    frame_clear_o = 1'b0;
    frame_bad_o = 1'b0;
  end

  // One frame held for one edge; idle lines then show the inverse so a stale value never passes
  task automatic send(input logic [6:0] a, input logic c, input logic b);
    @(posedge mclk_i) #1;
    frame_valid_o = 1'b1;
    frame_addr_o = a;
    frame_clear_o = c;
    frame_bad_o = b;
    @(posedge mclk_i) #1;
    frame_valid_o = 1'b0;
    frame_addr_o = ~a;
    frame_clear_o = ~c;
    frame_bad_o = ~b;
  endtask
endmodule // sbc_mcu_model

`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the bus status bank
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import sbc_pkg::*;
;
  logic mclk_i = 0, rstn_i = 0, soft_reset_i = 0, restart_i = 0, restart_fail_i = 0, sleep_wake_i = 0;
  logic reset_pin_stuck_high_i = 0, failsafe_input_fault_i = 0, wdog_fail_i = 0, wdog_ok_i = 0;
  logic fail_outputs_i = 0, wake_pattern_i = 0, can_supply_low_i = 0, can_thermal_i = 0;
  logic can_tx_input_stuck_i = 0, can_bus_stuck_i = 0, can_txd_i = 1, can_bus_recessive_i = 1;
  sbc_can_mode_t can_mode_i = CAN_OFF;
  logic [2:0] lin_thermal_i = 0, lin_tx_input_stuck_i = 0, lin_bus_stuck_i = 0, lin_wake_or_off_i = 0;
  logic [2:0] lin_txd_i = 3'h7, lin_bus_recessive_i = 3'h7, lin_tx_en_o;
  wire logic frame_valid_i, frame_clear_i, frame_bad_i;
  wire logic [6:0] frame_addr_i;
  logic rd_valid_o, thermal_level_one_o, can_tx_en_o;
  logic [7:0] rd_data_o, device_info_status_o, bus_comm_status_a_o, bus_comm_status_b_o;
  int n_mismatch = 0, checked = 0, cyc = 0;

  // Short transmitter hold keeps the recovery scenario brief
  sbc_bus_status #(.LIN_CH(3), .EN_CYCLES(4)) u_dut (.mclk_i, .rstn_i, .soft_reset_i, .restart_i,
    .frame_valid_i, .frame_addr_i, .frame_clear_i, .frame_bad_i, .restart_fail_i, .sleep_wake_i,
    .reset_pin_stuck_high_i, .failsafe_input_fault_i, .wdog_fail_i, .wdog_ok_i, .fail_outputs_i,
    .can_mode_i, .wake_pattern_i, .can_supply_low_i, .can_thermal_i, .can_tx_input_stuck_i,
    .can_bus_stuck_i, .can_txd_i, .can_bus_recessive_i, .lin_thermal_i, .lin_tx_input_stuck_i,
    .lin_bus_stuck_i, .lin_wake_or_off_i, .lin_txd_i, .lin_bus_recessive_i, .rd_valid_o, .rd_data_o,
    .device_info_status_o, .bus_comm_status_a_o, .bus_comm_status_b_o, .thermal_level_one_o,
    .can_tx_en_o, .lin_tx_en_o);
  sbc_mcu_model u_mcu (.mclk_i(mclk_i), .frame_valid_o(frame_valid_i), .frame_addr_o(frame_addr_i),
    .frame_clear_o(frame_clear_i), .frame_bad_o(frame_bad_i));

  // Clock and hang guard
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task tick;
    @(posedge mclk_i) #1;
  endtask

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read or clear one register and judge the answer
  task rd(input logic [6:0] a, input logic c, input logic [7:0] e);
    u_mcu.send(a, c, 1'b0);
    chk("rd_valid", 8'h01, {7'h00, rd_valid_o});
    chk("rd_data", e, rd_data_o);
  endtask

  task t_dev;
    restart_fail_i = 1; tick; restart_fail_i = 0;
    rd(ADDR_DEV, 1'b1, 8'h40);
    chk("dev", 8'h00, device_info_status_o);
    sleep_wake_i = 1; tick; sleep_wake_i = 0;
    repeat (3)
    begin
      wdog_fail_i = 1; tick; wdog_fail_i = 0; tick;
    end
    chk("dev", 8'h88, device_info_status_o);
    wdog_ok_i = 1; tick; wdog_ok_i = 0;
    chk("dev", 8'h80, device_info_status_o);
    u_mcu.send(ADDR_DEV, 1'b1, 1'b1);
    chk("rd_valid", 8'h00, {7'h00, rd_valid_o});
    chk("dev", 8'h82, device_info_status_o);
    fail_outputs_i = 1; reset_pin_stuck_high_i = 1; failsafe_input_fault_i = 1; wdog_fail_i = 1; tick;
    reset_pin_stuck_high_i = 0; failsafe_input_fault_i = 0; wdog_fail_i = 0;
    chk("dev", 8'hb7, device_info_status_o);
    rd(ADDR_DEV, 1'b1, 8'hb7);
    chk("dev", 8'h05, device_info_status_o);
    fail_outputs_i = 0; wdog_ok_i = 1; tick; wdog_ok_i = 0;
    rd(ADDR_DEV, 1'b1, 8'h01);
    chk("dev", 8'h00, device_info_status_o);
  endtask

  task t_can;
    can_supply_low_i = 1; tick; tick;
    chk("bus_a", 8'h00, bus_comm_status_a_o);
    can_mode_i = CAN_WAKE; tick;
    chk("bus_a", 8'h00, bus_comm_status_a_o);
    wake_pattern_i = 1; tick; tick;
    chk("bus_a", 8'h01, bus_comm_status_a_o);
    chk("can_tx_en", 8'h00, {7'h00, can_tx_en_o});
    can_supply_low_i = 0; can_mode_i = CAN_NORMAL;
    rd(ADDR_BUS_A, 1'b1, 8'h01);
    can_txd_i = 0; can_tx_input_stuck_i = 1; tick; can_tx_input_stuck_i = 0; tick; tick;
    chk("bus_a", 8'h04, bus_comm_status_a_o);
    chk("can_tx_en", 8'h00, {7'h00, can_tx_en_o});
    can_txd_i = 1; repeat (3) tick;
    chk("can_tx_en", 8'h00, {7'h00, can_tx_en_o});
    tick;
    chk("can_tx_en", 8'h00, {7'h00, can_tx_en_o});
    tick;
    chk("can_tx_en", 8'h01, {7'h00, can_tx_en_o});
    can_bus_stuck_i = 1; tick; can_bus_stuck_i = 0;
    rd(ADDR_BUS_A, 1'b1, 8'h06);
    can_thermal_i = 1; tick; can_thermal_i = 0;
    chk("thermal", 8'h01, {7'h00, thermal_level_one_o});
    lin_tx_input_stuck_i = 3'h1; lin_thermal_i = 3'h2; lin_bus_stuck_i = 3'h4; tick;
    lin_tx_input_stuck_i = 0; lin_thermal_i = 0; lin_bus_stuck_i = 0;
    chk("bus_a", 8'h42, bus_comm_status_a_o);
    chk("bus_b", 8'h1a, bus_comm_status_b_o);
    chk("lin_tx_en", 8'h00, {5'h00, lin_tx_en_o});
  endtask

  task t_restart;
    sleep_wake_i = 1; tick; sleep_wake_i = 0;
    restart_i = 1; tick; restart_i = 0;
    chk("dev", 8'h80, device_info_status_o);
    chk("bus_a", 8'h42, bus_comm_status_a_o);
    chk("bus_b", 8'h1a, bus_comm_status_b_o);
    u_mcu.send(7'h46, 1'b0, 1'b0);
    chk("rd_valid", 8'h00, {7'h00, rd_valid_o});
    soft_reset_i = 1; tick; soft_reset_i = 0;
    rd(ADDR_DEV, 1'b0, 8'h00);
    rd(ADDR_BUS_A, 1'b0, 8'h00);
    rd(ADDR_BUS_B, 1'b0, 8'h00);
    chk("lin_tx_en", 8'h07, {5'h00, lin_tx_en_o});
  endtask

  // Wake/off mode lets a stuck transmit input leave lock-out, hold time still applies
  task t_lin_off;
    lin_txd_i = 3'h6; lin_tx_input_stuck_i = 3'h1; tick; lin_tx_input_stuck_i = 0; tick; tick;
    chk("bus_a", 8'h40, bus_comm_status_a_o);
    chk("lin_tx_en", 8'h06, {5'h00, lin_tx_en_o});
    lin_wake_or_off_i = 3'h1; tick; tick; lin_txd_i = 3'h7; repeat (3) tick;
    chk("lin_tx_en", 8'h06, {5'h00, lin_tx_en_o});
    tick;
    chk("lin_tx_en", 8'h07, {5'h00, lin_tx_en_o});
    lin_wake_or_off_i = 0;
  endtask

  // Receive-only mode runs the supply comparator
  task t_rxonly;
    can_mode_i = CAN_RXONLY; can_supply_low_i = 1; tick; can_supply_low_i = 0; tick;
    chk("bus_a", 8'h41, bus_comm_status_a_o);
  endtask

  task tally_and_finish;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge mclk_i);
    #1 rstn_i = 1;
    rd(ADDR_BUS_B, 1'b1, 8'h00);
    t_dev();
    t_can();
    t_restart();
    t_lin_off();
    t_rxonly();
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
